// ---- oss_params.svh ----
// Constants for the output step sequencer
// How it works
// - A fixed-value parameter holds its programmed value for the whole step.
// - A carry-over parameter keeps its entry value; the programmed value is ignored.
// - A ramped parameter moves linearly from entry value to target over the duration.
// - Waveform and per-phase angles always behave as fixed values.
// - Reference phase angle is zero; other phases add their per-step offsets.
// - Step duration is programmable in seconds or milliseconds.
// - Jump count 1 to 9999; zero means jump forever.
// - A looping step runs one more time than its jump count.
// - Continue and end apply when jumping is off or the count is used up; hold applies even with a jump pending.
// - Either branch request moves at once to its programmed step.
// - At step end: continue goes next, end goes to step 0, hold waits.
// - With hold and a pending jump, hold first, jump on resume.
// - With hold and count exhausted, resume goes to the next step.
// - A holding step with stop alignment holds only after reaching the stop phase.
// - Each step drives its 2-bit sync code while it runs.
// - Start alignment sets the reference phase; other phases add their angles.
// - Without start alignment the phase continues from the previous step.
// - Stop alignment extends the step until the stop phase, at most one cycle.
// - Ramped values stay at their final value while waiting for stop phase.
// - Without stop alignment the step ends as soon as its duration elapses.
// - In DC mode both phase alignments are treated as disabled.
// - A per-step enable emits a trigger pulse with global polarity and width.
// - Step 0 is standby; a start always enters step 1.
// - Ending into step 0 uses step 0 duration and behaviours before standby.
// - Stop returns to step 0; resume advances to the next step, or takes a pending jump.
`ifndef OSS_PARAMS_SVH
`define OSS_PARAMS_SVH
`define OSS_CLK_NS       10
`define OSS_MS_NS        1000000
`define OSS_MS_PER_S     26'h00003E8
`define OSS_NUM_STEPS    16
`define OSS_FREQ_SHIFT   8
`define OSS_A_CTRL       8'h00
`define OSS_A_STAT       8'h04
`define OSS_A_SEL        8'h08
`define OSS_A_STEP       8'h20
`define OSS_A_STEP_LAST  8'h38
`define OSS_CTRL_DC      0
`define OSS_CTRL_TLOW    1
`define OSS_CTRL_GO      2
`define OSS_CTRL_TW_LSB  16
`define OSS_STAT_FSM_LSB 0
`define OSS_STAT_STP_LSB 8
`define OSS_TW_RST       16'h000A
`endif

// ---- oss_pkg.sv ----
// Types shared by the output step sequencer
`include "oss_params.svh"
package oss_pkg;
  typedef enum logic [1:0] {BEH_CONST, BEH_KEEP, BEH_RAMP} oss_beh_t;
  typedef enum logic [1:0] {TERM_CONT, TERM_END, TERM_HOLD} oss_term_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STOPWAIT, ST_HOLD} oss_state_t;
  // One step, word 6 at the top, word 0 at the bottom
  typedef struct packed {
    logic [15:0] dc_level_setting; logic [15:0] ac_phase_voltage;
    logic [15:0] third_angle; logic [15:0] second_angle;
    logic [15:0] pad4; logic [15:0] freq;
    logic [17:0] pad3; oss_beh_t beh_dc; oss_beh_t beh_ac; oss_beh_t beh_freq;
    logic [1:0] pad3b; logic [1:0] wave; logic [1:0] pad3c; logic stop_en; logic start_en;
    logic [15:0] stop_phase; logic [15:0] start_phase;
    logic [7:0] pad1; logic [3:0] branch_b; logic [3:0] branch_a; logic [1:0] pad1b; logic [13:0] jump_count;
    logic [3:0] pad0; logic [3:0] loop_target_step; logic pad0b; logic jump_en; oss_term_t term;
    logic [1:0] sync; logic trig_en; logic unit_ms; logic [15:0] duration;
  } oss_step_t;
  typedef struct packed {
    logic wr; logic rd; logic [7:0] addr; logic [31:0] wdata;
  } oss_bus_t;
  typedef struct packed {
    logic start_request; logic stop_request; logic resume_request;
    logic branch_request_a; logic branch_request_b;
  } oss_ctl_t;
  typedef struct packed {
    logic [15:0] freq; logic [1:0] wave; logic [15:0] ac_phase_voltage; logic [15:0] dc_level_setting;
    logic [15:0] reference_phase; logic [15:0] second_phase; logic [15:0] third_phase;
    logic [1:0] sync; logic trig; logic [3:0] step; logic running;
  } oss_out_t;
  typedef struct packed {
    oss_step_t [`OSS_NUM_STEPS-1:0] tbl;
    logic [`OSS_NUM_STEPS-1:0][13:0] done;
    oss_step_t cur; oss_state_t fsm; logic [3:0] step; logic [3:0] sel;
    logic dc_mode; logic trig_low; logic [15:0] trig_width; logic [15:0] trig_cnt; logic trig;
    oss_ctl_t sy1; oss_ctl_t sy2; oss_ctl_t sy3;
    logic [16:0] pre; logic [25:0] elapsed; logic [31:0] acc; logic [15:0] ph2; logic [15:0] ph3;
    logic [2:0][15:0] val; logic [2:0][15:0] base;
    logic busy; logic [1:0] par; logic [3:0] div_bit; logic [47:0] rem; logic [15:0] quo;
    logic [31:0] rdata;
  } oss_st_t;
endpackage

// ---- oss_sequencer.sv ----
// Step sequencer: step table, step flow, ramps, phase alignment and trigger
`include "oss_params.svh"
module oss_sequencer #(
  parameter int MS_CYCLES = `OSS_MS_NS / `OSS_CLK_NS
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Register port
  input  wire oss_pkg::oss_bus_t bus,
  output logic [31:0]            rdata,
  // Panel and control I/O requests, asynchronous levels
  input  wire oss_pkg::oss_ctl_t ctl,
  // Output settings, sync code and trigger
  output oss_pkg::oss_out_t      out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Programmed target of parameter p (0 freq, 1 ac, 2 dc)
  function automatic logic [15:0] tgt(input oss_pkg::oss_step_t st, input logic [1:0] p);
    logic [15:0] r;
    r = st.dc_level_setting;
    if (p == 2'h0) begin
      r = st.freq;
    end else if (p == 2'h1) begin
      r = st.ac_phase_voltage;
    end
    return r;
  endfunction

  // Behaviour of parameter p
  function automatic oss_pkg::oss_beh_t beh(input oss_pkg::oss_step_t st, input logic [1:0] p);
    oss_pkg::oss_beh_t r;
    r = st.beh_dc;
    if (p == 2'h0) begin
      r = st.beh_freq;
    end else if (p == 2'h1) begin
      r = st.beh_ac;
    end
    return r;
  endfunction

  // Numerator of the ramp fraction: |target - base| * elapsed
  function automatic logic [47:0] numer(input logic [15:0] b, input logic [15:0] t, input logic [25:0] el);
    logic [15:0] d;
    d = (t >= b) ? 16'(t - b) : 16'(b - t);
    return {6'h00, 42'(42'(d) * 42'(el))};
  endfunction

  // Load a step into the running slot and set up its entry values
  function automatic oss_pkg::oss_st_t enter_step(input oss_pkg::oss_st_t a, input logic [3:0] k);
    oss_pkg::oss_st_t r;
    oss_pkg::oss_step_t t;
    r = a;
    t = a.tbl[k];
    r.cur = t;
    r.step = k;
    r.fsm = oss_pkg::ST_RUN;
    r.elapsed = 26'h0000000;
    r.busy = 1'b0;
    for (int p = 0; p < 3; p++) begin
      r.base[p] = a.val[p];
      if (beh(t, 2'(p)) == oss_pkg::BEH_CONST) begin
        r.val[p] = tgt(t, 2'(p));
      end
      // carry-over keeps value; ramp starts from entry value
    end
    // start phase alignment, not in DC mode
    if (t.start_en && !a.dc_mode) begin
      r.acc = {t.start_phase, 16'h0000};
    end
    if (t.trig_en) begin
      r.trig_cnt = a.trig_width;
    end
    return r;
  endfunction

  // Jump decision and next step, used at step end and on resume
  function automatic oss_pkg::oss_st_t resolve(input oss_pkg::oss_st_t a);
    oss_pkg::oss_st_t r;
    logic             jmp;
    r = a;
    jmp = a.cur.jump_en && ((a.cur.jump_count == 14'h0000) || (a.done[a.step] < a.cur.jump_count));
    if (jmp) begin
      if (a.cur.jump_count != 14'h0000) begin
        r.done[a.step] = 14'(a.done[a.step] + 14'h0001);
      end
      r = enter_step(r, a.cur.loop_target_step);
    end else if (a.cur.term == oss_pkg::TERM_END) begin
      r = enter_step(r, 4'h0);
    end else begin
      // continue, or hold resumed after count used up
      r = enter_step(r, 4'(a.step + 4'h1));
    end
    return r;
  endfunction

  // Step completion after duration and any stop phase wait
  function automatic oss_pkg::oss_st_t complete(input oss_pkg::oss_st_t a);
    oss_pkg::oss_st_t r;
    r = a;
    if (a.step == 4'h0) begin
      // step 0 ramp-down finished, now standby
      r.fsm = oss_pkg::ST_IDLE;
    end else if (a.cur.term == oss_pkg::TERM_HOLD) begin
      // hold comes before any pending jump
      r.fsm = oss_pkg::ST_HOLD;
    end else begin
      r = resolve(a);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State and derived terms

  oss_pkg::oss_st_t  s_q;
  oss_pkg::oss_st_t  s_d;
  oss_pkg::oss_ctl_t rq;
  logic              tick;
  logic              go;
  logic              step_hit;
  logic [2:0]        widx;
  logic [25:0]       total;
  logic [31:0]       acc_nx;
  logic [47:0]       sh;
  logic              crossed;

  // Rising edges of synchronised requests; first stage never read here
  assign rq = oss_pkg::oss_ctl_t'(s_q.sy2 & ~s_q.sy3);

  // one free-running millisecond tick for all steps
  assign tick = (s_q.pre == 17'(MS_CYCLES - 1));

  // Step-word window decode
  assign step_hit = (bus.addr >= `OSS_A_STEP) && (bus.addr <= `OSS_A_STEP_LAST) && (bus.addr[1:0] == 2'h0);
  assign widx     = 3'(8'(bus.addr - `OSS_A_STEP) >> 2);

  // duration in milliseconds, seconds scaled up
  assign total = s_q.cur.unit_ms ? 26'(s_q.cur.duration) : 26'(26'(s_q.cur.duration) * `OSS_MS_PER_S);

  // phase accumulator advances every cycle from the same clock
  assign acc_nx = s_q.acc + 32'({16'h0000, s_q.val[0]} << `OSS_FREQ_SHIFT);

  // Divisor shifted to the current quotient bit
  assign sh = {22'h000000, total} << s_q.div_bit;

  // reference phase passes the stop phase this cycle; wrap safe
  assign crossed = 32'(acc_nx - {s_q.cur.stop_phase, 16'h0000}) < 32'(acc_nx - s_q.acc);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  // Bus, timebase, ramp divider and step flow
  always_comb begin
    s_d = s_q;
    go = 1'b0;
    s_d.rdata = 32'h00000000;
    s_d.sy1 = ctl;
    s_d.sy2 = s_q.sy1;
    s_d.sy3 = s_q.sy2;
    go = rq.start_request;

    // Register writes; table edits only take effect at the next step entry
    if (bus.wr) begin
      if (bus.addr == `OSS_A_CTRL) begin
        s_d.dc_mode = bus.wdata[`OSS_CTRL_DC];
        s_d.trig_low = bus.wdata[`OSS_CTRL_TLOW];
        s_d.trig_width = bus.wdata[`OSS_CTRL_TW_LSB +: 16];
        go = go | bus.wdata[`OSS_CTRL_GO];
      end else if (bus.addr == `OSS_A_SEL) begin
        s_d.sel = bus.wdata[3:0];
      end else if (step_hit) begin
        s_d.tbl[s_q.sel][{widx, 5'h00} +: 32] = bus.wdata;
      end
    end

    // Register reads, unmapped addresses read zero
    if (bus.rd) begin
      if (bus.addr == `OSS_A_CTRL) begin
        s_d.rdata[`OSS_CTRL_DC] = s_q.dc_mode;
        s_d.rdata[`OSS_CTRL_TLOW] = s_q.trig_low;
        s_d.rdata[`OSS_CTRL_TW_LSB +: 16] = s_q.trig_width;
      end else if (bus.addr == `OSS_A_STAT) begin
        s_d.rdata[`OSS_STAT_FSM_LSB +: 2] = s_q.fsm;
        s_d.rdata[`OSS_STAT_STP_LSB +: 4] = s_q.step;
      end else if (bus.addr == `OSS_A_SEL) begin
        s_d.rdata[3:0] = s_q.sel;
      end else if (step_hit) begin
        s_d.rdata = s_q.tbl[s_q.sel][{widx, 5'h00} +: 32];
      end
    end

    // Free-running timebase and phase
    s_d.pre = tick ? 17'h00000 : 17'(s_q.pre + 17'h00001);
    s_d.acc = acc_nx;
    s_d.trig_cnt = (s_q.trig_cnt != 16'h0000) ? 16'(s_q.trig_cnt - 16'h0001) : 16'h0000;

    // serial divide: value = base +/- |diff| * elapsed / total
    if (s_q.busy) begin
      if (s_q.rem >= sh) begin
        s_d.rem = 48'(s_q.rem - sh);
        s_d.quo[s_q.div_bit] = 1'b1;
      end
      if (s_q.div_bit == 4'h0) begin
        if (beh(s_q.cur, s_q.par) == oss_pkg::BEH_RAMP) begin
          if (tgt(s_q.cur, s_q.par) >= s_q.base[s_q.par]) begin
            s_d.val[s_q.par] = 16'(s_q.base[s_q.par] + s_d.quo);
          end else begin
            s_d.val[s_q.par] = 16'(s_q.base[s_q.par] - s_d.quo);
          end
        end
        if (s_q.par == 2'h2) begin
          s_d.busy = 1'b0;
        end else begin
          s_d.par = 2'(s_q.par + 2'h1);
          s_d.div_bit = 4'hF;
          s_d.quo = 16'h0000;
          s_d.rem = numer(s_q.base[s_d.par], tgt(s_q.cur, s_d.par), s_q.elapsed);
        end
      end else begin
        s_d.div_bit = 4'(s_q.div_bit - 4'h1);
      end
    end

    // Requests win over the step's own flow: stop, then branches
    if ((s_q.fsm != oss_pkg::ST_IDLE) && rq.stop_request && (s_q.step != 4'h0)) begin
      s_d = enter_step(s_d, 4'h0);
    end else if ((s_q.fsm != oss_pkg::ST_IDLE) && rq.branch_request_a) begin
      // branch ignores duration, stop phase and termination
      s_d = enter_step(s_d, s_q.cur.branch_a);
    end else if ((s_q.fsm != oss_pkg::ST_IDLE) && rq.branch_request_b) begin
      s_d = enter_step(s_d, s_q.cur.branch_b);
    end else begin
      unique case (s_q.fsm)
        oss_pkg::ST_IDLE: begin
          // a run always starts at step 1
          if (go) begin
            s_d.done = '0;
            s_d = enter_step(s_d, 4'h1);
          end
        end
        oss_pkg::ST_RUN: begin
          if (s_q.elapsed >= total) begin
            // land exactly on target when the duration ends
            for (int p = 0; p < 3; p++) begin
              if (beh(s_q.cur, 2'(p)) == oss_pkg::BEH_RAMP) begin
                s_d.val[p] = tgt(s_q.cur, 2'(p));
              end
            end
            s_d.busy = 1'b0;
            // wait for stop phase; never in DC; zero frequency never crosses
            if (s_q.cur.stop_en && !s_q.dc_mode && (s_q.val[0] != 16'h0000)) begin
              s_d.fsm = oss_pkg::ST_STOPWAIT;
            end else begin
              // leave as soon as the duration is over
              s_d = complete(s_d);
            end
          end else if (tick) begin
            s_d.elapsed = 26'(s_q.elapsed + 26'h0000001);
            s_d.busy = 1'b1;
            s_d.par = 2'h0;
            s_d.div_bit = 4'hF;
            s_d.quo = 16'h0000;
            s_d.rem = numer(s_q.base[0], tgt(s_q.cur, 2'h0), s_d.elapsed);
          end
        end
        oss_pkg::ST_STOPWAIT: begin
          // ramps stay at final value, no divider runs here
          // a hold step only holds once the stop phase is reached
          if (crossed) begin
            s_d = complete(s_d);
          end
        end
        oss_pkg::ST_HOLD: begin
          // resume advances, taking a pending jump first
          if (rq.resume_request) begin
            s_d = resolve(s_d);
          end
        end
      endcase
    end

    // reference at zero, other phases offset by their angles
    s_d.ph2 = 16'(s_d.acc[31:16] + s_d.cur.second_angle);
    s_d.ph3 = 16'(s_d.acc[31:16] + s_d.cur.third_angle);
    // global polarity applied to the pulse
    s_d.trig = (s_d.trig_cnt != 16'h0000) ^ s_d.trig_low;
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
      s_q.trig_width <= `OSS_TW_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign rdata = s_q.rdata;

  // waveform and angles come straight from the step; sync code
  assign out = '{
    freq:             s_q.val[0],
    wave:             s_q.cur.wave,
    ac_phase_voltage: s_q.val[1],
    dc_level_setting: s_q.val[2],
    reference_phase:  s_q.acc[31:16],
    second_phase:     s_q.ph2,
    third_phase:      s_q.ph3,
    sync:             s_q.cur.sync,
    trig:             s_q.trig,
    step:             s_q.step,
    running:          (s_q.fsm != oss_pkg::ST_IDLE)
  };

endmodule // oss_sequencer

// ---- oss_seq_properties.sv ----
// Port checks for the output step sequencer
module oss_seq_properties (
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              rst,
  // Register port
  input wire oss_pkg::oss_bus_t bus,
  input wire logic [31:0]       rdata,
  // Requests and outputs
  input wire oss_pkg::oss_ctl_t ctl,
  input wire oss_pkg::oss_out_t out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  // standby step, run start, sync and waveform per step, requests
  reset_standby_a: assert property ($fell(rst) |-> !out.running && out.step == 4'h0)
    else $error("reset left the sequencer outside standby");
  standby_step_zero_a: assert property (!out.running |-> out.step == 4'h0)
    else $error("standby away from step 0");
  run_opens_one_a: assert property ($rose(out.running) |-> out.step == 4'h1)
    else $error("run did not open at step 1");
  start_pin_run_a: assert property (
    $rose(ctl.start_request) && !out.running |-> ##[1:8] out.running)
    else $error("start request not taken");
  sync_per_step_a: assert property (
    $past(out.running) && out.running && $stable(out.step) |-> $stable(out.sync))
    else $error("sync code moved inside a step");
  wave_fixed_a: assert property (
    $past(out.running) && out.running && $stable(out.step) |-> $stable(out.wave))
    else $error("waveform moved inside a step");
  branch_a_moves_a: assert property (
    $rose(ctl.branch_request_a) && !ctl.stop_request && out.running && out.step != 4'h0
      |-> ##[1:8] $changed(out.step))
    else $error("first branch request not taken");
  branch_b_moves_a: assert property (
    $rose(ctl.branch_request_b) && !ctl.stop_request && !ctl.branch_request_a && out.running
      && out.step != 4'h0 |-> ##[1:8] $changed(out.step))
    else $error("second branch request not taken");
  stop_to_zero_a: assert property (
    $rose(ctl.stop_request) && out.running && out.step != 4'h0 |-> ##[1:8] out.step == 4'h0)
    else $error("stop request did not reach step 0");
  // Main scenarios reached
  run_seen_c: cover property ($rose(out.running));
  run_end_seen_c: cover property ($fell(out.running));
  trig_seen_c: cover property ($changed(out.trig));
endmodule // oss_seq_properties

// ---- oss_panel_model.sv ----
// Panel and control connector model that raises request pins
module oss_panel_model (
  // Clock
  input wire logic          clk_sys,
  // Request pins
  output oss_pkg::oss_ctl_t ctl
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ctl = '0;
  ////////////////////////////////////////////////////////////////
  // One request: 0 start, 1 stop, 2 resume, 3 branch a, 4 branch b
  // Random lead-in mimics slow operators; each level stands 3 cycles
  task automatic press(input int k);
    repeat ($urandom % 4) @(posedge clk_sys);
    @(posedge clk_sys);
    ctl[4-k] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ctl[4-k] <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule // oss_panel_model

// ---- tb.sv ----
// Self-checking bench for the output step sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  oss_pkg::oss_bus_t bus = '0;
  logic [31:0]       rdata;
  oss_pkg::oss_ctl_t ctl;
  oss_pkg::oss_out_t out;
  int                n_mismatch = 0;
  int                tests_run = 0;
  int                ntrig = 0;
  int                nhigh = 0;
  int                n0;
  int                h0;
  logic              trig_q = 1'b0;
  logic [31:0]       d;
  logic [15:0]       va;
  logic [15:0]       vb;
  logic [1:0]        s1;
  logic [1:0]        s2;
  ////////////////////////////////////////////////////////////////
  // Clock, design with a 100-cycle millisecond tick, panel model
  always #5 clk_sys = ~clk_sys;
  oss_sequencer #(.MS_CYCLES(100)) uut (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
    .ctl(ctl), .out(out));
  oss_panel_model panel (.clk_sys(clk_sys), .ctl(ctl));
  // Trigger edge and active-cycle counters (idle level low)
  always @(posedge clk_sys) begin
    trig_q <= out.trig;
    if (out.trig === 1'b1) nhigh <= nhigh + 1;
    if (out.trig === 1'b1 && trig_q === 1'b0) ntrig <= ntrig + 1;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask
  // Bus cycles: strobes last one cycle, read data taken the cycle after
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    @(posedge clk_sys);
    v = rdata;
  endtask
  // Step word 0, always in milliseconds
  function automatic logic [31:0] w0(int dur, int trg, int snc, int term, int jen, int tgt);
    return 32'(dur) | 32'h00010000 | 32'(trg << 17 | snc << 18 | term << 20 | jen << 22 | tgt << 24);
  endfunction
  // Model: value a parameter leaves a step with (keep holds entry)
  function automatic logic [15:0] ends_at(int beh, logic [15:0] entry, logic [15:0] prog);
    return (beh == 1) ? entry : prog;
  endfunction
  task automatic prog(input logic [3:0] n, input logic [31:0] a, b, c, e);
    wr(8'h08, {28'h0, n});
    wr(8'h20, a);
    wr(8'h24, b);
    wr(8'h2C, c);
    wr(8'h38, e);
  endtask
  // Bounded waits on the design's own outputs
  task automatic wstep(input logic [3:0] s, input int lim);
    int i;
    for (i = 0; i < lim && out.step !== s; i++) @(posedge clk_sys);
    chk(out.step, s, "step");
  endtask
  task automatic wstby();
    int i;
    for (i = 0; i < 400 && out.running !== 1'b0; i++) @(posedge clk_sys);
    chk(out.running, 0, "standby");
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(28));
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h04, d);
    chk(d, 32'h0, "status after reset");
    rd(8'h00, d);
    chk(d, 32'h000A0000, "control after reset");
    rd(8'h10, d);
    chk(d, 32'h0, "unmapped read");
    wr(8'h08, 32'h5);
    wr(8'h24, 32'h0032270F);
    rd(8'h24, d);
    chk(d, 32'h0032270F, "count 9999 readback");
    // Unmapped write must leave everything alone; all data bits and high address bits toggle
    wr(8'hC4, 32'hFFFFFFFF);
    rd(8'hC4, d);
    chk(d, 32'h0, "unmapped write");
    wr(8'h38, 32'hFFFFFFFF);
    rd(8'h38, d);
    chk(d, 32'hFFFFFFFF, "step word readback");
    $display("test registers done");
    va = 16'($urandom % 32'h4000);
    vb = va + 16'h8000;
    s1 = 2'($urandom);
    s2 = 2'($urandom);
    prog(4'h0, w0(1, 0, 0, 0, 0, 0), 32'h0, 32'h0, 32'h0);
    prog(4'h1, w0(2, 0, s1, 0, 0, 0), 32'h0, 32'h0, {16'h0, va});
    prog(4'h2, w0(4, 0, s2, 0, 0, 0), 32'h0, 32'h00000800, {16'h0, vb});
    prog(4'h3, w0(1, 0, 0, 1, 0, 0), 32'h0, 32'h00000400, 32'h0000FFFF);
    wr(8'h00, 32'h000A0004);
    wstep(4'h1, 50);
    chk(out.ac_phase_voltage, va, "const value");
    chk(out.sync, s1, "sync code");
    wstep(4'h2, 400);
    chk(out.sync, s2, "sync code");
    repeat (150) @(posedge clk_sys);
    chk(out.ac_phase_voltage > va && out.ac_phase_voltage < vb, 1, "ramp midway");
    wstep(4'h3, 400);
    chk(out.ac_phase_voltage, ends_at(2, va, vb), "ramp end");
    repeat (50) @(posedge clk_sys);
    chk(out.ac_phase_voltage, ends_at(1, vb, 16'hFFFF), "keep value");
    wstep(4'h0, 300);
    chk(out.ac_phase_voltage, 0, "step 0 ramp-down");
    wstby();
    $display("test flow done");
    prog(4'h1, w0(1, 1, 0, 1, 1, 1), 32'd2, 32'h0, 32'h0);
    n0 = ntrig;
    h0 = nhigh;
    panel.press(0);
    wstep(4'h1, 50);
    wstep(4'h0, 1000);
    chk(32'(ntrig - n0), 3, "executions");
    chk(32'(nhigh - h0), 30, "trigger width");
    wstby();
    wr(8'h08, 32'h1);
    wr(8'h24, 32'h00020000);
    panel.press(0);
    repeat (900) @(posedge clk_sys);
    chk(out.step, 4'h1, "endless jump");
    panel.press(3);
    wstep(4'h2, 20);
    panel.press(1);
    wstep(4'h0, 20);
    wstby();
    $display("test jumps done");
    prog(4'h1, w0(1, 1, 0, 2, 1, 1), 32'h1, 32'h0, 32'h0);
    prog(4'h2, w0(20, 0, 0, 0, 0, 0), 32'h00300000, 32'h0, 32'h0);
    prog(4'h3, w0(1, 0, 0, 2, 0, 0), 32'h0, 32'h0, 32'h0);
    n0 = ntrig;
    panel.press(0);
    repeat (250) @(posedge clk_sys);
    rd(8'h04, d);
    chk(d, 32'h00000103, "hold before jump");
    panel.press(2);
    repeat (250) @(posedge clk_sys);
    rd(8'h04, d);
    chk(d, 32'h00000103, "hold after jump");
    chk(32'(ntrig - n0), 2, "jump on resume");
    panel.press(2);
    wstep(4'h2, 20);
    panel.press(4);
    wstep(4'h3, 20);
    repeat (250) @(posedge clk_sys);
    rd(8'h04, d);
    chk(d, 32'h00000303, "hold at end");
    panel.press(1);
    wstep(4'h0, 20);
    wstby();
    $display("test hold done");
    // phases, DC mode, trigger polarity
    // Stop phase lies 1000 cycles past the aligned start, far beyond the 1 ms duration
    va = 16'($urandom);
    vb = 16'($urandom);
    prog(4'h1, w0(1, 1, 0, 0, 0, 0), 32'h0, 32'h00000023, {va, 16'h0000});
    wr(8'h28, 32'h0A001000);
    wr(8'h30, 32'h00004000);
    wr(8'h34, {vb, va});
    prog(4'h2, w0(1, 0, 0, 1, 0, 0), 32'h0, 32'h0, 32'h0);
    wr(8'h00, 32'h000A0004);
    wstep(4'h1, 20);
    chk(out.freq, 32'h00004000, "const frequency");
    chk(out.dc_level_setting, va, "const dc level");
    chk(out.wave, 2, "waveform");
    chk(16'(out.reference_phase - 16'h1000) < 16'h0100, 1, "start phase");
    chk(16'(out.second_phase - out.reference_phase), va, "second angle");
    chk(16'(out.third_phase - out.reference_phase), vb, "third angle");
    repeat (300) @(posedge clk_sys);
    chk(out.step, 4'h1, "stop phase wait");
    wstep(4'h2, 1000);
    chk(16'(out.reference_phase - 16'h0A00) < 16'h0040, 1, "stop phase");
    wstby();
    wr(8'h00, 32'h000A0007);
    wstep(4'h1, 20);
    chk(out.trig, 0, "trigger active low");
    wstep(4'h2, 210);
    wstby();
    chk(out.trig, 1, "trigger idle high");
    $display("test phases done");
    summarize();
  end
  // Watchdog far beyond the expected few thousand cycles
  initial begin
    #400000;
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    summarize();
  end
endmodule // tb

bind oss_sequencer oss_seq_properties props (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
  .ctl(ctl), .out(out));
